// ==== design/smp_pkg.sv ====
// Constants shared by the signal monitor front-panel indicator logic.
// Assumes a single 25 MHz system clock; all times are held in milliseconds.
package smp_pkg;

   // ----------------------------------------------------------------------
   // Clock and time base
   // ----------------------------------------------------------------------
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned MS_PER_S = 1000;
   localparam int unsigned MS_CYCLES_DEF = CLK_HZ / MS_PER_S;
   localparam int unsigned PRE_W = 16;
   localparam int unsigned MS_W = 13;

   // ----------------------------------------------------------------------
   // Flash rates and display intervals, in ms
   // ----------------------------------------------------------------------
   localparam int unsigned FLASH_2HZ_HALF_MS = 250;
   localparam int unsigned FLASH_4HZ_HALF_MS = 125;
   localparam int unsigned PULSE_PERIOD_MS = 2000;
   localparam int unsigned PULSE_ON_MS = 100;
   localparam int unsigned LAMP_TEST_MS = 300;
   localparam int unsigned FAULT_SNAP_MS = 6000;
   localparam int unsigned FAULT_INVOLVED_MS = 2000;

   // ----------------------------------------------------------------------
   // Channels and synchronised pin positions
   // ----------------------------------------------------------------------
   localparam int unsigned CHANNELS = 16;
   localparam int unsigned PIN_COUNT = 8;
   localparam int unsigned PIN_BUTTON = 0;
   localparam int unsigned PIN_EXT_RESET = 1;
   localparam int unsigned PIN_WD_SWITCH = 2;
   localparam int unsigned PIN_RED_ENABLE = 3;
   localparam int unsigned PIN_SF1 = 4;
   localparam int unsigned PIN_SF2 = 5;
   localparam int unsigned PIN_FLASH_DRIVE = 6;
   localparam int unsigned PIN_CARD_ABSENT = 7;

   // ----------------------------------------------------------------------
   // Channel status display phases during fault mode
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      SMP_SHOW_SNAP = 2'b01,
      SMP_SHOW_INVOLVED = 2'b10
   } smp_fdisp_t;

endpackage

// ==== design/smp_panel_indicators.sv ====
// Front-panel lamp drive and one-shot reset handling of a signal monitor.
// Fault flags and channel states come from logic on core_clk; panel switches and field-sensed inputs are pins.
//
// Behaviour
// (R1) Line-power lamp flashes 2 Hz during low line voltage.
// (R2) Line-power lamp flashes 4 Hz during the minimum flash interval.
// (R3) Line-power lamp steady once line voltage is restored above brownout.
// (R4) Line-power lamp off while line voltage is under 80 Vac.
// (R5) Dc-supply lamp lit on 24 V fault, dark otherwise.
// (R6) Controller watchdog lamp steady on controller watchdog fault.
// (R7) Watchdog lamp pulses every 2 s when monitoring disabled or line low.
// (R8) Conflict lamp lit on conflicting-signal fault.
// (R9) Diagnostic lamp lit on internal watchdog, memory test or supply fault.
// (R10) Red-absence lamp steady on loss of red on any channel.
// (R11) Red-absence lamp pulses every 2 s when red monitoring is inhibited.
// (R12) Dual-indication lamp lit on any dual indication fault.
// (R13) Sequence lamp lit when minimum yellow clearance was not met.
// (R14) Card-absent lamp lit while the program card is missing.
// (R15) In diagnostic display, card-absent lamp flashes the event number.
// (R16) Recurring-pulse lamp lit when a fault came from recurring pulses.
// (R17) Normally the 48 channel lamps show every active colour.
// (R18) In fault mode show fault-time signals 6 s, then involved channels 2 s.
// (R19) Panel reset returns the monitor circuitry to non-failed.
// (R20) Each reset assertion is one event; a stuck source cannot hold reset.
// (R21) Every accepted reset lights all lamps for 300 ms.
// (R22) Reset button also enters and steps the diagnostic display; the code only steps it (diag_step) while diag_display_mode is set.
// (R23) Red, dual and sequence monitoring enabled only while red enable active.
// (R24) Special functions disable only red-absence; function one may be inverted.
// (R25) Rates come from prescalers; steady fault beats flashing disabled state.
// (R26) The two-second pulse has a short fixed on-time parameter.
module smp_panel_indicators
   import smp_pkg::*;
#(
   parameter int unsigned MS_CYCLES = MS_CYCLES_DEF,
   parameter int unsigned F2_HALF_MS = FLASH_2HZ_HALF_MS,
   parameter int unsigned F4_HALF_MS = FLASH_4HZ_HALF_MS,
   parameter int unsigned PULSE_MS = PULSE_PERIOD_MS,
   parameter int unsigned PULSE_ON = PULSE_ON_MS,
   parameter int unsigned TEST_MS = LAMP_TEST_MS,
   parameter int unsigned SNAP_MS = FAULT_SNAP_MS,
   parameter int unsigned INVOLVED_MS = FAULT_INVOLVED_MS
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Panel and field pins
   input wire logic reset_button,
   input wire logic external_reset,
   input wire logic watchdog_monitor_enable_switch,
   input wire logic red_enable_input,
   input wire logic special_function_1,
   input wire logic special_function_2,
   input wire logic flash_drive_input,
   input wire logic program_card_absent,
   // Configuration
   input wire logic special_function_1_invert,
   // Line and supply status
   input wire logic line_below_80vac,
   input wire logic low_line_voltage,
   input wire logic min_flash_interval,
   input wire logic line_below_watchdog_level,
   input wire logic dc_supply_fault,
   // Fault flags
   input wire logic controller_watchdog_fault,
   input wire logic conflict_fault,
   input wire logic internal_watchdog_fault,
   input wire logic memory_test_fault,
   input wire logic internal_supply_fault,
   input wire logic red_absence_fault,
   input wire logic green_yellow_dual_fault,
   input wire logic green_yellow_red_dual_fault,
   input wire logic sequence_fault,
   input wire logic recurring_pulse_fault,
   // Diagnostic display
   input wire logic diag_display_mode,
   input wire logic [1:0] diag_event_number,
   // Channel state
   input wire logic fault_mode,
   input wire logic [CHANNELS-1:0] channel_red,
   input wire logic [CHANNELS-1:0] channel_yellow,
   input wire logic [CHANNELS-1:0] channel_green,
   input wire logic [CHANNELS-1:0] fault_channels,
   // Fault lamps
   output logic line_power_lamp,
   output logic dc_supply_fault_lamp,
   output logic controller_watchdog_fault_lamp,
   output logic conflict_lamp,
   output logic diagnostic_lamp,
   output logic red_absence_lamp,
   output logic dual_indication_lamp,
   output logic sequence_lamp,
   output logic program_card_absent_lamp,
   output logic recurring_pulse_lamp,
   // Channel status lamps
   output logic [CHANNELS-1:0] channel_red_lamp,
   output logic [CHANNELS-1:0] channel_yellow_lamp,
   output logic [CHANNELS-1:0] channel_green_lamp,
   // Monitor control
   output logic monitor_reset,
   output logic diag_step,
   output logic red_monitor_enable,
   output logic dual_monitor_enable,
   output logic sequence_monitor_enable,
   output logic red_absence_monitor_enable
);

   // ----------------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------------
   if (MS_CYCLES < 2 || MS_CYCLES >= (1 << PRE_W)) begin : g_chk_pre
      $error("MS_CYCLES out of range");
   end
   if (SNAP_MS >= (1 << MS_W) || PULSE_MS >= (1 << MS_W) || INVOLVED_MS >= (1 << MS_W) ||
       TEST_MS >= (1 << MS_W) ||
       PULSE_ON == 0 || PULSE_ON >= PULSE_MS || F2_HALF_MS == 0 || F4_HALF_MS == 0 ||
       TEST_MS == 0 || SNAP_MS == 0 || INVOLVED_MS == 0 || 6 * F2_HALF_MS > PULSE_MS) begin : g_chk_ms
      $error("Millisecond interval out of range");
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   logic [PIN_COUNT-1:0] pin_raw;
   logic [PIN_COUNT-1:0] pin_meta;
   logic [PIN_COUNT-1:0] pin_sync;

   assign pin_raw = {program_card_absent, flash_drive_input, special_function_2, special_function_1,
                     red_enable_input, watchdog_monitor_enable_switch, external_reset, reset_button};

   always_ff @(posedge core_clk) begin
      if (reset) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
      end
   end

   // ----------------------------------------------------------------------
   // Millisecond prescaler and flash generators
   // ----------------------------------------------------------------------
   logic [PRE_W-1:0] pre_cnt;
   logic ms_tick;
   logic [MS_W-1:0] f2_cnt;
   logic [MS_W-1:0] f4_cnt;
   logic [MS_W-1:0] pulse_cnt;
   logic flash_2hz;
   logic flash_4hz;
   logic pulse_on;

   assign ms_tick = (pre_cnt == PRE_W'(MS_CYCLES - 1));

   always_ff @(posedge core_clk) begin
      if (reset || ms_tick) begin
         pre_cnt <= '0; // [R25]
      end else begin
         pre_cnt <= pre_cnt + PRE_W'(1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         f2_cnt <= '0;
         flash_2hz <= 1'b0;
      end else if (ms_tick) begin
         if (f2_cnt == MS_W'(F2_HALF_MS - 1)) begin
            f2_cnt <= '0;
            flash_2hz <= ~flash_2hz; // [R1]
         end else begin
            f2_cnt <= f2_cnt + MS_W'(1);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         f4_cnt <= '0;
         flash_4hz <= 1'b0;
      end else if (ms_tick) begin
         if (f4_cnt == MS_W'(F4_HALF_MS - 1)) begin
            f4_cnt <= '0;
            flash_4hz <= ~flash_4hz; // [R2]
         end else begin
            f4_cnt <= f4_cnt + MS_W'(1);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         pulse_cnt <= '0;
      end else if (ms_tick) begin
         if (pulse_cnt == MS_W'(PULSE_MS - 1)) begin
            pulse_cnt <= '0;
         end else begin
            pulse_cnt <= pulse_cnt + MS_W'(1);
         end
      end
   end

   assign pulse_on = (pulse_cnt < MS_W'(PULSE_ON)); // [R26]

   // ----------------------------------------------------------------------
   // One-shot reset and diagnostic stepping
   // ----------------------------------------------------------------------
   // Each source has its own edge detector, so a source stuck high blocks only itself, never the other.
   logic [1:0] rst_prev;
   logic button_evt;
   logic ext_evt;
   logic accept_evt;
   logic [MS_W-1:0] test_cnt;
   logic lamp_test;

   assign button_evt = pin_sync[PIN_BUTTON] & ~rst_prev[0];
   assign ext_evt = pin_sync[PIN_EXT_RESET] & ~rst_prev[1];
   assign accept_evt = ext_evt | (button_evt & ~diag_display_mode);
   assign lamp_test = (test_cnt != '0);

   always_ff @(posedge core_clk) begin
      if (reset) begin
         rst_prev <= 2'h0;
         monitor_reset <= 1'b0;
         diag_step <= 1'b0;
      end else begin
         rst_prev <= {pin_sync[PIN_EXT_RESET], pin_sync[PIN_BUTTON]}; // [R20]
         monitor_reset <= accept_evt; // [R19]
         diag_step <= button_evt & diag_display_mode; // [R22]
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         test_cnt <= '0;
      end else if (accept_evt) begin
         test_cnt <= MS_W'(TEST_MS); // [R21]
      end else if (ms_tick && lamp_test) begin
         test_cnt <= test_cnt - MS_W'(1);
      end
   end

   // ----------------------------------------------------------------------
   // Monitoring enables
   // ----------------------------------------------------------------------
   logic sf_active;
   logic red_inhibit;
   logic wd_inhibit;

   assign sf_active = (pin_sync[PIN_SF1] ^ special_function_1_invert) | pin_sync[PIN_SF2]; // [R24]
   assign red_inhibit = ~pin_sync[PIN_RED_ENABLE] | sf_active | pin_sync[PIN_FLASH_DRIVE];
   assign wd_inhibit = ~pin_sync[PIN_WD_SWITCH] | line_below_watchdog_level;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         red_monitor_enable <= 1'b0;
         dual_monitor_enable <= 1'b0;
         sequence_monitor_enable <= 1'b0;
         red_absence_monitor_enable <= 1'b0;
      end else begin
         red_monitor_enable <= pin_sync[PIN_RED_ENABLE]; // [R23]
         dual_monitor_enable <= pin_sync[PIN_RED_ENABLE];
         sequence_monitor_enable <= pin_sync[PIN_RED_ENABLE];
         red_absence_monitor_enable <= pin_sync[PIN_RED_ENABLE] & ~sf_active; // [R24]
      end
   end

   // ----------------------------------------------------------------------
   // Fault lamps
   // ----------------------------------------------------------------------
   logic next_line_power;
   logic next_card;
   logic [MS_W-1:0] diag_slot;

   assign diag_slot = pulse_cnt / MS_W'(F2_HALF_MS);

   always_comb begin
      if (line_below_80vac) begin
         next_line_power = 1'b0; // [R4]
      end else if (min_flash_interval) begin
         next_line_power = flash_4hz; // [R2]
      end else if (low_line_voltage) begin
         next_line_power = flash_2hz; // [R1]
      end else begin
         next_line_power = 1'b1; // [R3]
      end
      if (diag_display_mode) begin
         next_card = ~diag_slot[0] && (diag_slot < MS_W'({diag_event_number, 1'b0})); // [R15]
      end else begin
         next_card = pin_sync[PIN_CARD_ABSENT]; // [R14]
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         line_power_lamp <= 1'b0;
         dc_supply_fault_lamp <= 1'b0;
         controller_watchdog_fault_lamp <= 1'b0;
         conflict_lamp <= 1'b0;
         diagnostic_lamp <= 1'b0;
         red_absence_lamp <= 1'b0;
         dual_indication_lamp <= 1'b0;
         sequence_lamp <= 1'b0;
         program_card_absent_lamp <= 1'b0;
         recurring_pulse_lamp <= 1'b0;
      end else begin
         line_power_lamp <= lamp_test | next_line_power;
         dc_supply_fault_lamp <= lamp_test | dc_supply_fault; // [R5]
         controller_watchdog_fault_lamp <= lamp_test | controller_watchdog_fault | (wd_inhibit & pulse_on); // [R6] [R7] [R25]
         conflict_lamp <= lamp_test | conflict_fault; // [R8]
         diagnostic_lamp <= lamp_test | internal_watchdog_fault | memory_test_fault | internal_supply_fault; // [R9]
         red_absence_lamp <= lamp_test | red_absence_fault | (red_inhibit & pulse_on); // [R10] [R11] [R25]
         dual_indication_lamp <= lamp_test | green_yellow_dual_fault | green_yellow_red_dual_fault; // [R12]
         sequence_lamp <= lamp_test | sequence_fault; // [R13]
         program_card_absent_lamp <= lamp_test | next_card;
         recurring_pulse_lamp <= lamp_test | recurring_pulse_fault; // [R16]
      end
   end

   // ----------------------------------------------------------------------
   // Channel status display
   // ----------------------------------------------------------------------
   logic fault_prev;
   smp_fdisp_t fdisp;
   logic [MS_W-1:0] fd_cnt;
   logic [CHANNELS-1:0] snap_red;
   logic [CHANNELS-1:0] snap_yellow;
   logic [CHANNELS-1:0] snap_green;
   logic [CHANNELS-1:0] show_red;
   logic [CHANNELS-1:0] show_yellow;
   logic [CHANNELS-1:0] show_green;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         fault_prev <= 1'b0;
         snap_red <= '0;
         snap_yellow <= '0;
         snap_green <= '0;
      end else begin
         fault_prev <= fault_mode;
         if (fault_mode && !fault_prev) begin
            snap_red <= channel_red; // [R18]
            snap_yellow <= channel_yellow;
            snap_green <= channel_green;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset || !fault_mode || !fault_prev) begin
         fdisp <= SMP_SHOW_SNAP;
         fd_cnt <= '0;
      end else if (ms_tick) begin
         case (fdisp)
            SMP_SHOW_SNAP: begin
               if (fd_cnt == MS_W'(SNAP_MS - 1)) begin
                  fdisp <= SMP_SHOW_INVOLVED; // [R18]
                  fd_cnt <= '0;
               end else begin
                  fd_cnt <= fd_cnt + MS_W'(1);
               end
            end
            SMP_SHOW_INVOLVED: begin
               if (fd_cnt == MS_W'(INVOLVED_MS - 1)) begin
                  fdisp <= SMP_SHOW_SNAP;
                  fd_cnt <= '0;
               end else begin
                  fd_cnt <= fd_cnt + MS_W'(1);
               end
            end
            default: begin
               fdisp <= SMP_SHOW_SNAP;
               fd_cnt <= '0;
            end
         endcase
      end
   end

   always_comb begin
      if (!fault_mode) begin
         show_red = channel_red; // [R17]
         show_yellow = channel_yellow;
         show_green = channel_green;
      end else if (fdisp == SMP_SHOW_INVOLVED) begin
         show_red = fault_channels;
         show_yellow = fault_channels;
         show_green = fault_channels;
      end else begin
         show_red = snap_red;
         show_yellow = snap_yellow;
         show_green = snap_green;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         channel_red_lamp <= '0;
         channel_yellow_lamp <= '0;
         channel_green_lamp <= '0;
      end else begin
         channel_red_lamp <= show_red | {CHANNELS{lamp_test}}; // [R21]
         channel_yellow_lamp <= show_yellow | {CHANNELS{lamp_test}};
         channel_green_lamp <= show_green | {CHANNELS{lamp_test}};
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   sequence s_accept;
      accept_evt;
   endsequence
   sequence s_all_lit;
      line_power_lamp && conflict_lamp && diagnostic_lamp && (&channel_red_lamp) && (&channel_green_lamp);
   endsequence
   property p_lamp_test;
      s_accept |=> ##1 s_all_lit [*2];
   endproperty
   a_lamp_test: assert property (p_lamp_test) else $error("lamp test did not light the panel"); // [R21]
   property p_one_shot;
      accept_evt |=> !accept_evt ##0 monitor_reset;
   endproperty
   a_one_shot: assert property (p_one_shot) else $error("reset accepted twice in a row"); // [R20] [R19]
   property p_line_off;
      line_below_80vac && !lamp_test && !accept_evt |=> !line_power_lamp;
   endproperty
   a_line_off: assert property (p_line_off) else $error("line lamp lit under 80 Vac"); // [R4]
   property p_line_steady;
      !line_below_80vac && !min_flash_interval && !low_line_voltage |=> line_power_lamp;
   endproperty
   a_line_steady: assert property (p_line_steady) else $error("line lamp not steady"); // [R3]
   property p_wd_steady;
      controller_watchdog_fault [*2] |=> controller_watchdog_fault_lamp;
   endproperty
   a_wd_steady: assert property (p_wd_steady) else $error("watchdog fault lamp not steady"); // [R6] [R25]
   property p_dc_dark;
      !dc_supply_fault && !lamp_test && !accept_evt |=> !dc_supply_fault_lamp;
   endproperty
   a_dc_dark: assert property (p_dc_dark) else $error("dc lamp lit without fault"); // [R5]
   property p_diag;
      (internal_watchdog_fault || memory_test_fault || internal_supply_fault) |=> diagnostic_lamp;
   endproperty
   a_diag: assert property (p_diag) else $error("diagnostic lamp dark on fault"); // [R9]
   property p_red_enables;
      ##1 red_monitor_enable == $past(pin_sync[PIN_RED_ENABLE]) && sequence_monitor_enable == red_monitor_enable;
   endproperty
   a_red_enables: assert property (p_red_enables) else $error("monitor enables disagree"); // [R23]
   property p_sf_disable;
      sf_active |=> !red_absence_monitor_enable;
   endproperty
   a_sf_disable: assert property (p_sf_disable) else $error("red absence still enabled"); // [R24]
   property p_normal_channels;
      !fault_mode && !lamp_test && !accept_evt |=> channel_yellow_lamp == $past(channel_yellow);
   endproperty
   a_normal_channels: assert property (p_normal_channels) else $error("channel lamps wrong"); // [R17]

endmodule

// ==== verif/smp_field_model.sv ====
// Field-side model: panel switches, reset sources and sensed cabinet inputs.
// Assumes the bench calls set_pin from the core_clk domain.
module smp_field_model (
   input wire logic core_clk,
   output logic [7:0] pins
);
   timeunit 1ns;
   timeprecision 100ps;
   // Watchdog monitoring on and red enable sensed active at power-up.
   initial pins = 8'h0c;
   task automatic set_pin(input int idx, input logic val);
      @(posedge core_clk);
      #1 pins[idx] = val;
   endtask
   task automatic set_pins(input logic [7:0] val);
      @(posedge core_clk);
      #1 pins = val;
   endtask
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for the front-panel indicator block.
// Assumes short prescale parameters so each ms lasts four core_clk cycles.
module tb_top;
   import smp_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk, reset, inv, dmode, fmode, mrst, dstep;
   logic [7:0] pins, pv;
   logic [4:0] ln;
   logic [9:0] f, lamp;
   logic [1:0] ev;
   logic [3:0] en;
   logic [15:0] cr, cy, cg, fc, lr, ly, lg;
   logic [47:0] cap;
   int fail_count, checked, n, m, d;

   smp_field_model i_smp_field_model (.core_clk(core_clk), .pins(pins));
   smp_panel_indicators #(.MS_CYCLES(4), .F2_HALF_MS(4), .F4_HALF_MS(2), .PULSE_MS(24), .PULSE_ON(2),
      .TEST_MS(5), .SNAP_MS(12), .INVOLVED_MS(4)) i_smp_panel_indicators (
      .core_clk(core_clk), .reset(reset), .reset_button(pins[0]), .external_reset(pins[1]),
      .watchdog_monitor_enable_switch(pins[2]), .red_enable_input(pins[3]), .special_function_1(pins[4]),
      .special_function_2(pins[5]), .flash_drive_input(pins[6]), .program_card_absent(pins[7]),
      .special_function_1_invert(inv), .line_below_80vac(ln[0]), .low_line_voltage(ln[1]),
      .min_flash_interval(ln[2]), .line_below_watchdog_level(ln[3]), .dc_supply_fault(ln[4]),
      .controller_watchdog_fault(f[0]), .conflict_fault(f[1]), .internal_watchdog_fault(f[2]),
      .memory_test_fault(f[3]), .internal_supply_fault(f[4]), .red_absence_fault(f[5]),
      .green_yellow_dual_fault(f[6]), .green_yellow_red_dual_fault(f[7]), .sequence_fault(f[8]),
      .recurring_pulse_fault(f[9]), .diag_display_mode(dmode), .diag_event_number(ev), .fault_mode(fmode),
      .channel_red(cr), .channel_yellow(cy), .channel_green(cg), .fault_channels(fc),
      .line_power_lamp(lamp[0]), .dc_supply_fault_lamp(lamp[1]), .controller_watchdog_fault_lamp(lamp[2]),
      .conflict_lamp(lamp[3]), .diagnostic_lamp(lamp[4]), .red_absence_lamp(lamp[5]),
      .dual_indication_lamp(lamp[6]), .sequence_lamp(lamp[7]), .program_card_absent_lamp(lamp[8]),
      .recurring_pulse_lamp(lamp[9]), .channel_red_lamp(lr), .channel_yellow_lamp(ly),
      .channel_green_lamp(lg), .monitor_reset(mrst), .diag_step(dstep), .red_monitor_enable(en[0]),
      .dual_monitor_enable(en[1]), .sequence_monitor_enable(en[2]), .red_absence_monitor_enable(en[3]));

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask
   // Expected fault lamps with no line flashing; an inhibited pulse lamp always carries a steady fault.
   function automatic logic [9:0] exp_lamps();
      return {f[9], pins[7], f[8], f[6] | f[7], f[5], |f[4:2], f[1], f[0], ln[4], ~ln[0]};
   endfunction
   task automatic flip(input string nm, input int e);
      logic v;
      // The first edge may only be the switch of source, so a full half period is timed on the third.
      for (int r = 0; r < 3; r++) begin
         v = lamp[0];
         n = 0;
         while (lamp[0] === v && n < 99) begin
            cyc(1);
            n++;
         end
      end
      chk(nm, 16'(e), 16'(n));
   endtask
   // Any 96-cycle window spans exactly one two-second period.
   task automatic ones(input string nm, input int b, input int e);
      n = 0;
      repeat (96) begin
         cyc(1);
         n += int'(lamp[b] === 1'b1);
      end
      chk(nm, 16'(e), 16'(n));
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      core_clk = 0;
      forever #20 core_clk = ~core_clk;
   end
   initial begin
      repeat (6000) @(posedge core_clk);
      fail_count++;
      summarize();
   end

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   initial begin
      {reset, inv, dmode, fmode, ev, ln, f} = 21'h100000;
      {cr, cy, cg, fc} = '0;
      void'($urandom(89870));
      cyc(20);
      reset = 0;
      cyc(3);
      repeat (16) begin
         pv = {6'($urandom), 2'b00};
         inv = 1'($urandom);
         ev = 2'($urandom);
         fc = 16'($urandom);
         ln = 5'($urandom) & 5'h19;
         // An inhibited pulse lamp is given a steady fault, which must win over the pulse.
         f = 10'($urandom);
         f[0] = f[0] | ~pv[2] | ln[3];
         f[5] = f[5] | ~pv[3] | (pv[4] ^ inv) | pv[5] | pv[6];
         {cr, cy, cg} = 48'({$urandom, $urandom});
         i_smp_field_model.set_pins(pv);
         cyc(4);
         chk("fault lamps", 16'(exp_lamps()), 16'(lamp));
         chk("enables", {12'h0, pv[3] & ~((pv[4] ^ inv) | pv[5]), {3{pv[3]}}}, 16'(en));
         chk("red lamps", cr, lr);
         chk("yellow lamps", cy, ly);
         chk("green lamps", cg, lg);
      end
      {f, ln} = '0;
      inv = 1'b0;
      i_smp_field_model.set_pins(8'h0c);
      ln[1] = 1;
      flip("line slow", 16);
      ln[2] = 1;
      flip("line fast", 8);
      ln = '0;
      cyc(2);
      chk("line steady", 16'h1, 16'(lamp[0]));
      ln[3] = 1;
      ones("wd pulse", 2, 8);
      ln = '0;
      i_smp_field_model.set_pin(2, 0);
      cyc(4);
      ones("wd pulse", 2, 8);
      f[0] = 1;
      ones("wd steady", 2, 96);
      f[0] = 0;
      i_smp_field_model.set_pin(2, 1);
      i_smp_field_model.set_pin(3, 0);
      cyc(4);
      chk("enables", 16'h0, 16'(en));
      ones("red pulse", 5, 8);
      i_smp_field_model.set_pin(3, 1);
      for (int i = 4; i < 7; i++) begin
         i_smp_field_model.set_pin(i, 1);
         cyc(4);
         chk("enables", (i < 6) ? 16'h7 : 16'hf, 16'(en));
         ones("red pulse", 5, 8);
         i_smp_field_model.set_pin(i, 0);
      end
      inv = 1;
      cyc(4);
      chk("enables", 16'h7, 16'(en));
      inv = 0;
      dmode = 1;
      for (int e = 1; e < 4; e++) begin
         ev = 2'(e);
         ones("card flashes", 8, 16 * e);
      end
      for (int k = 0; k < 3; k++) begin
         dmode = (k == 2);
         i_smp_field_model.set_pin(k % 2, 1);
         {m, d, n} = 0;
         repeat (40) begin
            cyc(1);
            m += int'(mrst === 1'b1);
            d += int'(dstep === 1'b1);
            n += int'(lamp === 10'h3ff);
         end
         chk("reset events", (k < 2) ? 16'h10 : 16'h01, 16'(m * 16 + d));
         chk("lamp test", 16'h1, 16'((k < 2) ? (n >= 16 && n <= 24) : (n == 0)));
         i_smp_field_model.set_pin(k % 2, 0);
      end
      dmode = 0;
      {cr, cy, cg, fc} = {$urandom, $urandom};
      fmode = 1;
      cyc(1);
      cap = {cr, cy, cg};
      {cr, cy, cg} = ~cap;
      cyc(30);
      chk("snapshot", 16'h0, (cap[47:32] ^ lr) | (cap[31:16] ^ ly) | (cap[15:0] ^ lg));
      cyc(26);
      chk("involved", 16'h0, (fc ^ lr) | (fc ^ ly) | (fc ^ lg));
      summarize();
   end
endmodule
